// *** rtl/crm_pkg.sv ***
// package: register map, field layout and constants of the rx mask block
//
// Operation
// - each masked standard identifier bit is compared; unmasked ones are ignored.
// - with type matching on, the frame type must equal the filter's type.
// - with type matching off, either frame type passes if masked bits match.
// - each of eighteen extended mask bits includes or ignores its bit.
// - storing an accepted message sets that buffer's occupied flag.
// - a message aimed at an occupied buffer sets its overrun flag.
// - buffer words go to the DMA memory, not the register space.
// - first word bit 1 is the substitute remote request flag.
// - first word bit 0 selects extended or standard identifier.
// - second word holds extended identifier 17..6 in bits 11..0.
// - each data word holds byte m low and byte m+1 high.
// - the status word gets the five-bit number of the matching filter.
// - the filter code is written only into receive buffers.
// - with type matching on, filter type select one takes extended only, zero standard only.
// - the target buffer field picks the buffer; all ones means the FIFO.
package crm_pkg;
   // register byte offsets on the APB side
   localparam logic [7:0] OFF_MSK_SID = 8'h00;
   localparam logic [7:0] OFF_MSK_EID = 8'h04;
   localparam logic [7:0] OFF_FULL_LO = 8'h08;
   localparam logic [7:0] OFF_FULL_HI = 8'h0C;
   localparam logic [7:0] OFF_OVF_LO = 8'h10;
   localparam logic [7:0] OFF_OVF_HI = 8'h14;
   localparam logic [7:0] OFF_CTRL0 = 8'h18;
   localparam logic [7:0] OFF_IRQ_STS = 8'h28;
   localparam logic [7:0] OFF_IRQ_MSK = 8'h2C;
   localparam int NUM_REGS = 12;
   // mask register fields
   localparam int MSK_SID_LSB = 5;
   localparam int MSK_FRAME_TYPE_MATCH_ENABLE_BIT = 3;
   // buffer control byte fields
   localparam int CTL_DIR_BIT = 7;
   localparam int CTL_REQ_BIT = 3;
   localparam logic [7:0] CTL_WMASK = 8'h8F;
   localparam int NUM_CTRL_BUF = 8;
   // buffer word layout in DMA memory
   localparam int WORDS_PER_BUF = 8;
   localparam logic [2:0] WORD_STAT = 3'h7;
   localparam logic [3:0] FIFO_TARGET = 4'hF;
   // interrupt status bits
   localparam int IRQ_STORE = 0;
   localparam int IRQ_OVF = 1;
   localparam int IRQ_FIFO = 2;
   localparam int IRQ_TXDONE = 3;
   localparam int NUM_IRQ = 4;
   // reset values
   localparam logic [31:0] RST_ZERO32 = 32'h0000_0000;
   typedef enum logic {ST_IDLE, ST_WRITE} crm_state_t;
endpackage : crm_pkg

// *** rtl/crm_accept.sv ***
// acceptance compare of one message against one filter and mask
`timescale 1ns/100ps
module crm_accept (
   // message
   input wire logic [10:0] msg_sid,
   input wire logic [17:0] msg_eid,
   input wire logic msg_ide,
   // filter
   input wire logic [10:0] flt_sid,
   input wire logic [17:0] flt_eid,
   input wire logic flt_ext,
   // mask
   input wire logic [10:0] msk_sid,
   input wire logic [17:0] msk_eid,
   input wire logic type_match_en,
   // result
   output logic accept
);
   logic sid_ok;
   logic eid_ok;
   logic type_ok;

   // a zero mask bit turns that position into a don't care
   always_comb
   begin
      sid_ok = ((msg_sid ^ flt_sid) & msk_sid) == 11'h000;
      // standard frames carry no extended bits, so only sid counts
      eid_ok = !msg_ide ||
               (((msg_eid ^ flt_eid) & msk_eid) == 18'h0_0000);
      type_ok = !type_match_en || (msg_ide == flt_ext);
      accept = sid_ok && eid_ok && type_ok;
   end
endmodule : crm_accept

// *** rtl/crm_rx_mask.sv ***
// rx acceptance mask, buffer flags, buffer writer and apb registers
`timescale 1ns/100ps
module crm_rx_mask (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // received message from the protocol engine
   input wire logic rx_msg_valid,
   input wire logic [10:0] rx_sid,
   input wire logic [17:0] rx_eid,
   input wire logic rx_ide,
   input wire logic rx_srr,
   input wire logic rx_rtr,
   input wire logic [3:0] rx_dlc,
   input wire logic [63:0] rx_data,
   // filter that is being tried for this message
   input wire logic [10:0] flt_sid,
   input wire logic [17:0] flt_eid,
   input wire logic flt_ext,
   input wire logic [4:0] flt_code,
   input wire logic [3:0] flt_target,
   // transmit completion from the protocol engine
   input wire logic tx_done,
   input wire logic [2:0] tx_done_idx,
   // dma memory write port, 16-bit words
   output logic dma_we,
   output logic [7:0] dma_addr,
   output logic [15:0] dma_wdata,
   // status towards the engine
   output logic fifo_push,
   output logic rx_busy,
   output logic tx_pend_valid,
   output logic [2:0] tx_pend_idx,
   output logic irq
);
   typedef struct packed {
      logic [10:0] msk_sid;
      logic frame_type_match_enable;
      logic [17:0] msk_eid;
      logic [31:0] full;
      logic [31:0] ovf;
      logic [crm_pkg::NUM_CTRL_BUF*8-1:0] ctrl;
      logic [crm_pkg::NUM_IRQ-1:0] ists;
      logic [crm_pkg::NUM_IRQ-1:0] imsk;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      crm_pkg::crm_state_t state;
      logic [2:0] word;
      logic [4:0] bidx;
      logic [10:0] standard_identifier;
      logic srr;
      logic ide;
      logic [17:0] extended_identifier;
      logic rtr;
      logic [3:0] data_length_code;
      logic [63:0] data;
      logic [4:0] code;
      logic dma_we;
      logic [7:0] dma_addr;
      logic [15:0] dma_wdata;
      logic fifo_push;
      logic busy;
      logic tx_pv;
      logic [2:0] tx_pi;
      logic irq;
   } crm_state_q_t;

   crm_state_q_t q;
   crm_state_q_t d;
   logic acc;
   logic wr_acc;
   logic [3:0] ridx;
   logic rhit;
   logic [1:0] best_pri;
   logic [7:0] cb;

   // register index from a byte address; misaligned or too high misses
   function automatic logic [4:0] reg_decode(input logic [7:0] a);
      logic hit;
      hit = (a[1:0] == 2'b00) && (a[7:2] < 6'(crm_pkg::NUM_REGS));
      return {hit, a[5:2]};
   endfunction : reg_decode

   // one 16-bit word of the buffer image in dma memory
   function automatic logic [15:0] buf_word(input crm_state_q_t s,
                                            input logic [2:0] w);
      logic [15:0] v;
      v = 16'h0000;
      unique case (w)
         3'h0: v = {3'b000, s.standard_identifier, s.srr, s.ide};
         3'h1: v = {4'h0, s.extended_identifier[17:6]};
         3'h2: v = {s.extended_identifier[5:0], s.rtr, 5'b0_0000, s.data_length_code};
         3'h3: v = s.data[15:0];
         3'h4: v = s.data[31:16];
         3'h5: v = s.data[47:32];
         3'h6: v = s.data[63:48];
         3'h7: v = {3'b000, s.code, 8'h00};
      endcase
      return v;
   endfunction : buf_word

   // register read value
   function automatic logic [31:0] reg_read(input crm_state_q_t s,
                                            input logic [3:0] i);
      logic [31:0] v;
      v = crm_pkg::RST_ZERO32;
      unique case ({i, 2'b00})
         crm_pkg::OFF_MSK_SID[5:0]:
            v[15:0] = {s.msk_sid, 1'b0, s.frame_type_match_enable, 1'b0, s.msk_eid[17:16]};
         crm_pkg::OFF_MSK_EID[5:0]: v[15:0] = s.msk_eid[15:0];
         crm_pkg::OFF_FULL_LO[5:0]: v[15:0] = s.full[15:0];
         crm_pkg::OFF_FULL_HI[5:0]: v[15:0] = s.full[31:16];
         crm_pkg::OFF_OVF_LO[5:0]: v[15:0] = s.ovf[15:0];
         crm_pkg::OFF_OVF_HI[5:0]: v[15:0] = s.ovf[31:16];
         crm_pkg::OFF_IRQ_STS[5:0]: v[3:0] = s.ists;
         crm_pkg::OFF_IRQ_MSK[5:0]: v[3:0] = s.imsk;
         default: v[15:0] = s.ctrl[(i - 4'd6) * 16 +: 16];
      endcase
      return v;
   endfunction : reg_read

   crm_accept u_accept (
      .msg_sid(rx_sid),
      .msg_eid(rx_eid),
      .msg_ide(rx_ide),
      .flt_sid(flt_sid),
      .flt_eid(flt_eid),
      .flt_ext(flt_ext),
      .msk_sid(q.msk_sid),
      .msk_eid(q.msk_eid),
      .type_match_en(q.frame_type_match_enable),
      .accept(acc)
   );

   assign {rhit, ridx} = reg_decode(paddr);
   // a write lands on the edge where the master sees pready high
   assign wr_acc = psel && penable && q.pready && pwrite && rhit;

   // next state: bus, flags, writer and transmit pick
   always_comb
   begin
      d = q;
      best_pri = 2'b00;
      cb = 8'h00;
      d.pready = 1'b0;
      d.dma_we = 1'b0;
      d.fifo_push = 1'b0;
      // one wait state so read data comes from a flop
      if (psel && penable && !q.pready)
      begin
         d.pready = 1'b1;
         d.pslverr = !rhit;
         d.prdata = rhit ? reg_read(q, ridx) : crm_pkg::RST_ZERO32;
      end
      // software writes; flag clears come first so hardware sets win
      if (wr_acc)
      begin
         unique case ({ridx, 2'b00})
            crm_pkg::OFF_MSK_SID[5:0]:
            begin
               d.msk_sid = pwdata[15:crm_pkg::MSK_SID_LSB];
               d.frame_type_match_enable = pwdata[crm_pkg::MSK_FRAME_TYPE_MATCH_ENABLE_BIT];
               d.msk_eid[17:16] = pwdata[1:0];
            end
            crm_pkg::OFF_MSK_EID[5:0]: d.msk_eid[15:0] = pwdata[15:0];
            crm_pkg::OFF_FULL_LO[5:0]:
               d.full[15:0] = q.full[15:0] & ~pwdata[15:0];
            crm_pkg::OFF_FULL_HI[5:0]:
               d.full[31:16] = q.full[31:16] & ~pwdata[15:0];
            crm_pkg::OFF_OVF_LO[5:0]:
               d.ovf[15:0] = q.ovf[15:0] & ~pwdata[15:0];
            crm_pkg::OFF_OVF_HI[5:0]:
               d.ovf[31:16] = q.ovf[31:16] & ~pwdata[15:0];
            crm_pkg::OFF_IRQ_STS[5:0]:
               d.ists = q.ists & ~pwdata[crm_pkg::NUM_IRQ-1:0];
            crm_pkg::OFF_IRQ_MSK[5:0]:
               d.imsk = pwdata[crm_pkg::NUM_IRQ-1:0];
            default:
               for (int b = 0; b < 2; b++)
               begin
                  d.ctrl[(ridx - 4'd6) * 16 + b * 8 +: 8] =
                     pwdata[b * 8 +: 8] & crm_pkg::CTL_WMASK;
               end
         endcase
      end
      // engine reports a sent message: drop its send request
      if (tx_done)
      begin
         d.ctrl[{tx_done_idx, 3'(crm_pkg::CTL_REQ_BIT)}] = 1'b0;
         d.ists[crm_pkg::IRQ_TXDONE] = 1'b1;
      end
      // receive path: route, check occupancy, then write eight words
      unique case (q.state)
         crm_pkg::ST_IDLE:
         begin
            if (rx_msg_valid && acc)
            begin
               cb = q.ctrl[flt_target[2:0] * 8 +: 8];
               if (flt_target == crm_pkg::FIFO_TARGET)
               begin
                  d.fifo_push = 1'b1;
                  d.ists[crm_pkg::IRQ_FIFO] = 1'b1;
               end
               else if (flt_target < 4'(crm_pkg::NUM_CTRL_BUF) &&
                        cb[crm_pkg::CTL_DIR_BIT])
               begin
                  // a transmit buffer never takes received data
                  d.fifo_push = 1'b0;
               end
               else if (q.full[flt_target])
               begin
                  d.ovf[flt_target] = 1'b1;
                  d.ists[crm_pkg::IRQ_OVF] = 1'b1;
               end
               else
               begin
                  d.state = crm_pkg::ST_WRITE;
                  d.bidx = {1'b0, flt_target};
                  d.word = 3'h0;
                  d.standard_identifier = rx_sid;
                  d.srr = rx_srr;
                  d.ide = rx_ide;
                  d.extended_identifier = rx_eid;
                  d.rtr = rx_rtr;
                  d.data_length_code = rx_dlc;
                  d.data = rx_data;
                  d.code = flt_code;
               end
            end
         end
         crm_pkg::ST_WRITE:
         begin
            d.dma_we = 1'b1;
            d.dma_addr = {q.bidx, q.word};
            d.dma_wdata = buf_word(q, q.word);
            d.word = q.word + 3'h1;
            if (q.word == crm_pkg::WORD_STAT)
            begin
               d.full[q.bidx] = 1'b1;
               d.ists[crm_pkg::IRQ_STORE] = 1'b1;
               d.state = crm_pkg::ST_IDLE;
            end
         end
      endcase
      d.busy = (d.state != crm_pkg::ST_IDLE);
      // highest priority pending transmit buffer, lowest index on a tie
      d.tx_pv = 1'b0;
      d.tx_pi = 3'h0;
      for (int b = 0; b < crm_pkg::NUM_CTRL_BUF; b++)
      begin
         cb = q.ctrl[b * 8 +: 8];
         if (cb[crm_pkg::CTL_DIR_BIT] && cb[crm_pkg::CTL_REQ_BIT] &&
             (!d.tx_pv || cb[1:0] > best_pri))
         begin
            d.tx_pv = 1'b1;
            d.tx_pi = 3'(b);
            best_pri = cb[1:0];
         end
      end
      d.irq = |(q.ists & q.imsk);
   end

   // all state in one register
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign dma_we = q.dma_we;
   assign dma_addr = q.dma_addr;
   assign dma_wdata = q.dma_wdata;
   assign fifo_push = q.fifo_push;
   assign rx_busy = q.busy;
   assign tx_pend_valid = q.tx_pv;
   assign tx_pend_idx = q.tx_pi;
   assign irq = q.irq;

   // every check below runs on the bus clock and sleeps in reset
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // the last buffer word and the occupied flag appear together
   a_full_on_store: assert property (
      q.dma_we && q.dma_addr[2:0] == crm_pkg::WORD_STAT
      |-> q.full[q.dma_addr[7:3]])
      else $error("occupied flag not set with status word");

   // status word carries the latched filter number
   a_code_in_stat: assert property (
      q.dma_we && q.dma_addr[2:0] == crm_pkg::WORD_STAT
      |-> q.dma_wdata == {3'b000, q.code, 8'h00})
      else $error("filter code missing from status word");

   // a message to an occupied buffer raises overrun and writes nothing
   a_ovf_on_full: assert property (
      q.state == crm_pkg::ST_IDLE && rx_msg_valid && acc &&
      flt_target != crm_pkg::FIFO_TARGET && q.full[flt_target] &&
      !(flt_target < 4'd8 && q.ctrl[flt_target[2:0] * 8 + 7])
      |=> q.ovf[$past(flt_target)] && !q.busy ##1 !q.dma_we)
      else $error("overrun not flagged");

   // occupied flags only fall after a software write
   a_full_sw_only: assert property (
      !$past(wr_acc) |-> (($past(q.full) & ~q.full) == 32'h0000_0000))
      else $error("occupied flag cleared by hardware");

   // overrun flags only fall after a software write
   a_ovf_sw_only: assert property (
      !$past(wr_acc) |-> (($past(q.ovf) & ~q.ovf) == 32'h0000_0000))
      else $error("overrun flag cleared by hardware");

   // all-ones target goes to the fifo and starts no buffer write
   a_fifo_route: assert property (
      q.state == crm_pkg::ST_IDLE && rx_msg_valid && acc &&
      flt_target == crm_pkg::FIFO_TARGET
      |=> fifo_push && !rx_busy ##1 !dma_we)
      else $error("fifo route failed");

   // a rejected message leaves the writer idle
   a_reject_idle: assert property (
      q.state == crm_pkg::ST_IDLE && rx_msg_valid &&
      (((rx_sid ^ flt_sid) & q.msk_sid) != 11'h000)
      |=> !rx_busy && !fifo_push)
      else $error("masked mismatch was accepted");

   // a stored message writes eight consecutive words
   a_eight_words: assert property (
      $rose(q.busy) |=> dma_we [*8] ##1 !dma_we)
      else $error("buffer write burst not eight words");

   // type matching: a frame of the wrong type is dropped
   a_type_match: assert property (
      q.state == crm_pkg::ST_IDLE && rx_msg_valid && q.frame_type_match_enable &&
      rx_ide != flt_ext |=> !rx_busy && !fifo_push)
      else $error("frame type mismatch accepted");

   // completion clears the send request of that buffer
   a_send_clear: assert property (
      tx_done |=> !q.ctrl[$past(tx_done_idx) * 8 + 3])
      else $error("send request not cleared");
endmodule : crm_rx_mask

// *** verif/crm_engine_model.sv ***
// protocol engine model: drives messages and filter hits, records dma words
`timescale 1ns/100ps
module crm_engine_model (
   // clock
   input wire logic pclk,
   // message and filter candidate towards the block
   output logic rx_msg_valid,
   output logic [10:0] rx_sid,
   output logic [17:0] rx_eid,
   output logic rx_ide,
   output logic rx_srr,
   output logic rx_rtr,
   output logic [3:0] rx_dlc,
   output logic [63:0] rx_data,
   output logic [10:0] flt_sid,
   output logic [17:0] flt_eid,
   output logic flt_ext,
   output logic [4:0] flt_code,
   output logic [3:0] flt_target,
   // transmit completion
   output logic tx_done,
   output logic [2:0] tx_done_idx,
   // dma write port and status from the block
   input wire logic dma_we,
   input wire logic [7:0] dma_addr,
   input wire logic [15:0] dma_wdata,
   input wire logic fifo_push,
   input wire logic rx_busy
);
   localparam logic [63:0] MSG_DATA = 64'h8877_6655_4433_2211;
   logic [15:0] mem [256];
   int wr_cnt = 0;
   int push_cnt = 0;
   // everything quiet at time zero
   initial
   begin
      {rx_msg_valid, rx_sid, rx_eid, rx_ide, rx_srr, rx_rtr, rx_dlc} = '0;
      {rx_data, flt_sid, flt_eid, flt_ext, flt_code, flt_target} = '0;
      {tx_done, tx_done_idx} = '0;
   end
   // dma ram image; unwritten words stay unknown so a miss never matches
   always @(posedge pclk)
   begin
      if (dma_we === 1'b1)
      begin
         mem[dma_addr] <= dma_wdata;
         wr_cnt <= wr_cnt + 1;
      end
      if (fifo_push === 1'b1)
         push_cnt <= push_cnt + 1;
   end
   // one message with its filter, then wait for the writer to go idle
   task send(input logic [10:0] s, input logic [17:0] e, input logic i,
             input logic [10:0] fs, input logic [17:0] fe, input logic fx,
             input logic [4:0] c, input logic [3:0] t);
      int n;
      @(posedge pclk);
      rx_msg_valid <= 1'b1;
      {rx_sid, rx_eid, rx_ide, rx_srr, rx_rtr, rx_dlc} <= {s, e, i, 6'h38};
      {flt_sid, flt_eid, flt_ext, flt_code, flt_target} <= {fs, fe, fx, c, t};
      rx_data <= MSG_DATA;
      @(posedge pclk);
      rx_msg_valid <= 1'b0;
      // fields are stale now, so show garbage rather than the old value
      {rx_sid, rx_eid, rx_data} <= ~{rx_sid, rx_eid, rx_data};
      repeat (2) @(posedge pclk);
      n = 0;
      while (rx_busy !== 1'b0 && n < 20)
      begin
         @(posedge pclk);
         n++;
      end
      @(posedge pclk);
   endtask : send
   // one-cycle completion pulse for a transmit buffer
   task tx_finish(input logic [2:0] idx);
      @(posedge pclk);
      tx_done <= 1'b1;
      tx_done_idx <= idx;
      @(posedge pclk);
      tx_done <= 1'b0;
      tx_done_idx <= ~idx;
   endtask : tx_finish
endmodule : crm_engine_model

// *** verif/crm_rx_mask_tb.sv ***
// self-checking bench for the acceptance mask, buffer flags and writer
`timescale 1ns/100ps
`define CHK(g, e) \
   begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module crm_rx_mask_tb;
   localparam logic [10:0] STANDARD_IDENTIFIER = 11'h5A5;
   localparam logic [17:0] EXTENDED_IDENTIFIER = 18'h2_B3C4;
   localparam logic [17:0] EZ = 18'h0_0000;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr, dma_addr;
   logic [31:0] pwdata, prdata;
   logic rx_msg_valid, rx_ide, rx_srr, rx_rtr, flt_ext, tx_done, dma_we;
   logic [10:0] rx_sid, flt_sid;
   logic [17:0] rx_eid, flt_eid;
   logic [3:0] rx_dlc, flt_target;
   logic [63:0] rx_data;
   logic [4:0] flt_code;
   logic [2:0] tx_done_idx, tx_pend_idx;
   logic [15:0] dma_wdata;
   logic fifo_push, rx_busy, tx_pend_valid;
   int error_cnt = 0;
   int total_checks = 0;
   int p;

   crm_rx_mask DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .rx_msg_valid(rx_msg_valid),
      .rx_sid(rx_sid), .rx_eid(rx_eid), .rx_ide(rx_ide), .rx_srr(rx_srr),
      .rx_rtr(rx_rtr), .rx_dlc(rx_dlc), .rx_data(rx_data),
      .flt_sid(flt_sid), .flt_eid(flt_eid), .flt_ext(flt_ext),
      .flt_code(flt_code), .flt_target(flt_target), .tx_done(tx_done),
      .tx_done_idx(tx_done_idx), .dma_we(dma_we), .dma_addr(dma_addr),
      .dma_wdata(dma_wdata), .fifo_push(fifo_push), .rx_busy(rx_busy),
      .tx_pend_valid(tx_pend_valid), .tx_pend_idx(tx_pend_idx), .irq(irq));

   crm_engine_model pe (
      .pclk(pclk), .rx_msg_valid(rx_msg_valid), .rx_sid(rx_sid),
      .rx_eid(rx_eid), .rx_ide(rx_ide), .rx_srr(rx_srr), .rx_rtr(rx_rtr),
      .rx_dlc(rx_dlc), .rx_data(rx_data), .flt_sid(flt_sid),
      .flt_eid(flt_eid), .flt_ext(flt_ext), .flt_code(flt_code),
      .flt_target(flt_target), .tx_done(tx_done), .tx_done_idx(tx_done_idx),
      .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
      .fifo_push(fifo_push), .rx_busy(rx_busy));

   // free-running 250 MHz clock
   initial
   begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end

   task conclude;
      if (error_cnt == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude

   // one apb transfer; request held until pready is seen at an edge
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge pclk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         error_cnt++;
         $display("ERROR %0t: bus never answered", $time);
         conclude();
      end
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask : wr

   task rc(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, x)
      `CHK(e, xe)
   endtask : rc

   // send one message and compare the number of dma words written
   task msg(input logic [10:0] s, input logic [17:0] e, input logic i,
            input logic [10:0] fs, input logic [17:0] fe, input logic fx,
            input logic [4:0] c, input logic [3:0] t, input int nw);
      int w;
      w = pe.wr_cnt;
      pe.send(s, e, i, fs, fe, fx, c, t);
      // the model's wait is bounded; a writer still busy is a hang
      if (rx_busy !== 1'b0)
      begin
         error_cnt++;
         $display("ERROR %0t: writer never went idle", $time);
         conclude();
      end
      `CHK(pe.wr_cnt - w, nw)
   endtask : msg

   // expected image of one stored buffer, srr and rtr sent as one
   task chk_buf(input logic [4:0] b, input logic [17:0] e, input logic i,
                input logic [4:0] c);
      `CHK(pe.mem[{b, 3'h0}], {3'h0, STANDARD_IDENTIFIER, 1'b1, i})
      `CHK(pe.mem[{b, 3'h1}], {4'h0, e[17:6]})
      `CHK(pe.mem[{b, 3'h2}], {e[5:0], 1'b1, 5'h00, 4'h8})
      for (int k = 0; k < 4; k++)
         `CHK(pe.mem[{b, k[2:0] + 3'h3}], pe.MSG_DATA[16 * k +: 16])
      `CHK(pe.mem[{b, 3'h7}], {3'h0, c, 8'h00})
   endtask : chk_buf

   // main sequence
   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++)
         rc(8'(4 * i), 32'h0000_0000);
      rc(8'h30, 32'h0000_0000, 1'b1);
      wr(crm_pkg::OFF_MSK_SID, 32'hFFFF_FFFF);
      rc(crm_pkg::OFF_MSK_SID, 32'h0000_FFEB);
      wr(crm_pkg::OFF_MSK_EID, 32'hFFFF_FFFF);
      rc(crm_pkg::OFF_MSK_EID, 32'h0000_FFFF);
      // plain standard frame into buffer 9
      msg(STANDARD_IDENTIFIER, EZ, 1'b0, STANDARD_IDENTIFIER, EZ, 1'b0, 5'h13, 4'h9, 8);
      chk_buf(5'h09, EZ, 1'b0, 5'h13);
      rc(crm_pkg::OFF_FULL_LO, 32'h0000_0200);
      // rejected frames touch neither flags nor memory
      msg(STANDARD_IDENTIFIER, EZ, 1'b0, 11'h5A4, EZ, 1'b0, 5'h01, 4'h9, 0);
      rc(crm_pkg::OFF_OVF_LO, 32'h0000_0000);
      msg(STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b1, STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b0, 5'h02, 4'hA, 0);
      msg(STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b1, STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b1, 5'h0A, 4'hA, 8);
      chk_buf(5'h0A, EXTENDED_IDENTIFIER, 1'b1, 5'h0A);
      wr(crm_pkg::OFF_MSK_SID, 32'h0000_FFE3);
      msg(STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b1, STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b0, 5'h0B, 4'hB, 8);
      msg(STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b1, STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER ^ 18'h1, 1'b0, 5'h0C, 4'hC, 0);
      wr(crm_pkg::OFF_MSK_EID, 32'h0000_FFFE);
      msg(STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER, 1'b1, STANDARD_IDENTIFIER, EXTENDED_IDENTIFIER ^ 18'h1, 1'b0, 5'h0C, 4'hC, 8);
      wr(crm_pkg::OFF_MSK_SID, 32'h0000_FFC3);
      msg(STANDARD_IDENTIFIER, EZ, 1'b0, 11'h5A4, EZ, 1'b0, 5'h0D, 4'hD, 8);
      rc(crm_pkg::OFF_FULL_LO, 32'h0000_3E00);
      // second message into a full buffer must not be stored
      msg(STANDARD_IDENTIFIER, EZ, 1'b0, STANDARD_IDENTIFIER, EZ, 1'b0, 5'h05, 4'h9, 0);
      rc(crm_pkg::OFF_OVF_LO, 32'h0000_0200);
      chk_buf(5'h09, EZ, 1'b0, 5'h13);
      wr(crm_pkg::OFF_FULL_LO, 32'h0000_0200);
      rc(crm_pkg::OFF_FULL_LO, 32'h0000_3C00);
      rc(crm_pkg::OFF_OVF_LO, 32'h0000_0200);
      wr(crm_pkg::OFF_OVF_LO, 32'h0000_0200);
      rc(crm_pkg::OFF_OVF_LO, 32'h0000_0000);
      // fifo target bypasses the buffers
      p = pe.push_cnt;
      msg(STANDARD_IDENTIFIER, EZ, 1'b0, STANDARD_IDENTIFIER, EZ, 1'b0, 5'h03, 4'hF, 0);
      `CHK(pe.push_cnt - p, 1)
      rc(crm_pkg::OFF_FULL_LO, 32'h0000_3C00);
      // interrupt: masked, unmasked, cleared
      `CHK(irq, 1'b0)
      rc(crm_pkg::OFF_IRQ_STS, 32'h0000_0007);
      wr(crm_pkg::OFF_IRQ_MSK, 32'h0000_000F);
      rc(crm_pkg::OFF_IRQ_MSK, 32'h0000_000F);
      `CHK(irq, 1'b1)
      wr(crm_pkg::OFF_IRQ_STS, 32'h0000_0007);
      rc(crm_pkg::OFF_IRQ_STS, 32'h0000_0000);
      `CHK(irq, 1'b0)
      // transmit pair: buffer 1 priority 3 beats buffer 0 priority 2
      wr(crm_pkg::OFF_CTRL0, 32'h0000_8B8A);
      rc(crm_pkg::OFF_CTRL0, 32'h0000_8B8A);
      `CHK(tx_pend_valid, 1'b1)
      `CHK(tx_pend_idx, 3'h1)
      msg(STANDARD_IDENTIFIER, EZ, 1'b0, STANDARD_IDENTIFIER, EZ, 1'b0, 5'h04, 4'h0, 0);
      rc(crm_pkg::OFF_FULL_LO, 32'h0000_3C00);
      pe.tx_finish(3'h1);
      rc(crm_pkg::OFF_CTRL0, 32'h0000_838A);
      `CHK(tx_pend_idx, 3'h0)
      pe.tx_finish(3'h0);
      rc(crm_pkg::OFF_CTRL0, 32'h0000_8382);
      `CHK(tx_pend_valid, 1'b0)
      rc(crm_pkg::OFF_IRQ_STS, 32'h0000_0008);
      `CHK(irq, 1'b1)
      conclude();
   end
endmodule : crm_rx_mask_tb
